// ==== rtl/tpwm_pkg.sv ====
// Shared constants and types of the 8-bit waveform timer
package tpwm_pkg;

   // Register offsets on the plain register port
   localparam logic [2:0] REG_CTRL_A = 3'h0;
   localparam logic [2:0] REG_CTRL_B = 3'h1;
   localparam logic [2:0] REG_COUNT = 3'h2;
   localparam logic [2:0] REG_CMP_A = 3'h3;
   localparam logic [2:0] REG_CMP_B = 3'h4;
   localparam logic [2:0] REG_FLAGS = 3'h5;
   localparam logic [2:0] REG_PIN_DIR = 3'h6;

   // Field positions
   localparam int ACT_A_LSB = 6;
   localparam int ACT_STRIDE = 2;
   localparam int MODE_LOW_LSB = 0;
   localparam int MODE_HIGH_BIT = 3;
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMP_LSB = 1;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'h00;
   localparam logic [7:0] RD_IDLE = 8'h00;

   // Counter extremes
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] CNT_STEP = 8'h01;

   // Waveform mode codes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PC_MAX = 3'h1;
   localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
   localparam logic [2:0] MODE_FAST_MAX = 3'h3;
   localparam logic [2:0] MODE_PC_CMP = 3'h5;
   localparam logic [2:0] MODE_FAST_CMP = 3'h7;

   // Output action codes
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // One register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } tpwm_bus_req_t;

endpackage : tpwm_pkg

// ==== rtl/tpwm_timer.sv ====
// 8-bit timer with clear-on-match, fast PWM and phase-correct PWM modes
`timescale 1ns/1ns
`default_nettype none

module tpwm_timer
   import tpwm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Prescaled timer clock enable
   input wire logic timer_tick,
   // Register port
   input wire tpwm_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // Waveform state and pins, index 0 is channel A
   output logic wave_out_a,
   output logic wave_out_b,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe
);

   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] count_q;
   logic dir_down_q;
   logic block_q;
   logic ovf_flag_q;
   logic [1:0] cmp_flag_q;
   logic [1:0] pin_dir_q;
   logic [1:0] wave_q;
   logic [1:0] up_seen_q;
   logic [7:0] cmp_q [2];
   logic [7:0] cmp_buf_q [2];
   logic [1:0] match;
   logic [1:0] wave_d;
   logic [2:0] waveform_mode;
   logic is_ctc;
   logic is_fast;
   logic is_pc;
   logic is_pwm;
   logic [7:0] top_val;
   logic at_top;
   logic at_bottom;
   logic going_up;
   logic wr_count;
   logic ovf_set;

   // Mode decode; field split over both control registers
   assign waveform_mode = {ctrl_b_q[MODE_HIGH_BIT],
                           ctrl_a_q[MODE_LOW_LSB +: 2]};
   assign is_ctc = waveform_mode == MODE_CLEAR_ON_MATCH;
   assign is_fast = waveform_mode == MODE_FAST_MAX ||
                    waveform_mode == MODE_FAST_CMP;
   assign is_pc = waveform_mode == MODE_PC_MAX ||
                  waveform_mode == MODE_PC_CMP;
   assign is_pwm = is_fast || is_pc;

   // Ceiling: compare A in modes 2, 5, 7, else the full 8-bit range
   assign top_val = (is_ctc || waveform_mode == MODE_FAST_CMP ||
                     waveform_mode == MODE_PC_CMP) ? cmp_q[0] : CNT_MAX;
   assign at_top = count_q == top_val;
   assign at_bottom = count_q == CNT_BOTTOM;
   // A match at bottom counts as an up-count match
   assign going_up = !dir_down_q || at_bottom;
   assign wr_count = bus_req.wr && bus_req.addr == REG_COUNT;

   // Counter; a tick-free cycle without a count write leaves it untouched
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         count_q <= COUNT_RESET;
         dir_down_q <= 1'b0;
      end
      else if (wr_count)
         count_q <= bus_req.wdata;
      else if (timer_tick)
      begin
         if (is_fast)
            // Wrap on the tick after reaching ceiling
            count_q <= at_top ? CNT_BOTTOM : count_q + CNT_STEP;
         else if (is_pc)
         begin
            // Ceiling turns straight to down, no hold; 510 ticks at ceiling 0xff, twice the ceiling otherwise
            if (!dir_down_q)
            begin
               if (at_top)
               begin
                  count_q <= count_q - CNT_STEP;
                  dir_down_q <= 1'b1;
               end
               else
                  count_q <= count_q + CNT_STEP;
            end
            else if (at_bottom)
            begin
               count_q <= count_q + CNT_STEP;
               dir_down_q <= 1'b0;
            end
            else
               count_q <= count_q - CNT_STEP;
         end
         else if (is_ctc && match[0])
            count_q <= CNT_BOTTOM;
         else
            // A missed match simply wraps through 0xff
            count_q <= count_q + CNT_STEP;
         if (!is_pc)
            dir_down_q <= 1'b0;
      end
   end

   // A count write hides compare matches for the next tick
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         block_q <= 1'b0;
      else if (wr_count)
         block_q <= 1'b1;
      else if (timer_tick)
         block_q <= 1'b0;
   end

   // Overflow event per mode
   always_comb
   begin
      if (is_fast)
         ovf_set = at_top;
      else if (is_pc)
         ovf_set = at_bottom && dir_down_q;
      else
         ovf_set = count_q == CNT_MAX && !(is_ctc && match[0]);
   end

   // Sticky flags; write one clears, a same-cycle set wins
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         ovf_flag_q <= 1'b0;
      else
         ovf_flag_q <= (ovf_flag_q && !(bus_req.wr &&
                        bus_req.addr == REG_FLAGS &&
                        bus_req.wdata[FLAG_OVF_BIT])) ||
                       (timer_tick && ovf_set);
   end

   // Control and pin direction registers
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ctrl_a_q <= CTRL_RESET;
         ctrl_b_q <= CTRL_RESET;
         pin_dir_q <= 2'h0;
      end
      else if (bus_req.wr)
      begin
         if (bus_req.addr == REG_CTRL_A)
            ctrl_a_q <= bus_req.wdata;
         if (bus_req.addr == REG_CTRL_B)
            ctrl_b_q <= bus_req.wdata;
         if (bus_req.addr == REG_PIN_DIR)
            pin_dir_q <= bus_req.wdata[1:0];
      end
   end

   // Per-channel compare, flag and waveform logic
   for (genvar ch = 0; ch < 2; ch++)
   begin : g_chan
      logic [1:0] act;
      logic ignore_match;
      logic cmp_wr;
      logic up_res;

      assign act = ctrl_a_q[ACT_A_LSB - ACT_STRIDE * ch +: 2];
      // Compare at ceiling with a PWM action is handled at top/bottom
      assign ignore_match = act[1] && cmp_q[ch] == top_val;
      assign cmp_wr = bus_req.wr &&
                      bus_req.addr == REG_CMP_A + 3'(ch);
      assign up_res = act[0];
      assign match[ch] = count_q == cmp_q[ch] && !block_q;

      // Software copy; also the active value outside PWM
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
            cmp_buf_q[ch] <= CMP_RESET;
         else if (cmp_wr)
            cmp_buf_q[ch] <= bus_req.wdata;
      end

      // Active compare; PWM loads it at the top of the slope
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
            cmp_q[ch] <= CMP_RESET;
         else if (cmp_wr && !is_pwm)
            cmp_q[ch] <= bus_req.wdata;
         else if (timer_tick && is_pwm && at_top && !dir_down_q)
            cmp_q[ch] <= cmp_buf_q[ch];
      end

      // Compare flag on equality, set wins over clear
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
            cmp_flag_q[ch] <= 1'b0;
         else
            cmp_flag_q[ch] <= (cmp_flag_q[ch] && !(bus_req.wr &&
                               bus_req.addr == REG_FLAGS &&
                               bus_req.wdata[FLAG_CMP_LSB + ch])) ||
                              (timer_tick && match[ch]);
      end

      // Up-count match seen since the last bottom
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
            up_seen_q[ch] <= 1'b0;
         else if (timer_tick && is_pc)
         begin
            if (match[ch] && going_up && !ignore_match)
               up_seen_q[ch] <= 1'b1;
            else if (at_bottom)
               up_seen_q[ch] <= 1'b0;
         end
      end

      // Next waveform level
      always_comb
      begin
         wave_d[ch] = wave_q[ch];
         if (timer_tick)
         begin
            if (is_pwm && act == ACT_TOGGLE)
            begin
               // Toggle only on A and only with mode high bit
               if (ch == 0 && waveform_mode[2] && match[ch])
                  wave_d[ch] = !wave_q[ch];
            end
            else if (is_fast && act[1])
            begin
               if (at_top)
                  wave_d[ch] = !up_res;
               else if (match[ch] && !ignore_match)
                  wave_d[ch] = up_res;
            end
            else if (is_pc && act[1])
            begin
               if (match[ch] && !ignore_match)
                  wave_d[ch] = going_up ? up_res : !up_res;
               else if (ignore_match && at_top)
                  wave_d[ch] = !up_res;
               else if (at_bottom && !up_seen_q[ch] && !ignore_match)
                  wave_d[ch] = up_res;
            end
            else if (!is_pwm && match[ch])
            begin
               case (act)
                  ACT_TOGGLE: wave_d[ch] = !wave_q[ch];
                  ACT_CLEAR: wave_d[ch] = 1'b0;
                  ACT_SET: wave_d[ch] = 1'b1;
                  default: wave_d[ch] = wave_q[ch];
               endcase
            end
         end
      end

      // Waveform state, cleared by system reset
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
            wave_q[ch] <= 1'b0;
         else
            wave_q[ch] <= wave_d[ch];
      end

      // Pin drive; port data is not modelled, so an idle pin shows 0
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
         begin
            pin_out[ch] <= 1'b0;
            pin_oe[ch] <= 1'b0;
         end
         else
         begin
            pin_out[ch] <= act != ACT_OFF && wave_q[ch];
            pin_oe[ch] <= pin_dir_q[ch];
         end
      end
   end

   assign wave_out_a = wave_q[0];
   assign wave_out_b = wave_q[1];

   // Read data, valid the cycle after the read strobe only
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !bus_req.rd)
         bus_rdata <= RD_IDLE;
      else
      begin
         case (bus_req.addr)
            REG_CTRL_A: bus_rdata <= ctrl_a_q;
            REG_CTRL_B: bus_rdata <= ctrl_b_q;
            REG_COUNT: bus_rdata <= count_q;
            REG_CMP_A: bus_rdata <= cmp_buf_q[0];
            REG_CMP_B: bus_rdata <= cmp_buf_q[1];
            REG_FLAGS: bus_rdata <= {5'h00, cmp_flag_q, ovf_flag_q};
            REG_PIN_DIR: bus_rdata <= {6'h00, pin_dir_q};
            default: bus_rdata <= RD_IDLE;
         endcase
      end
   end

endmodule : tpwm_timer

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench of the waveform timer
`timescale 1ns/1ns
`default_nettype none
module testbench
   import tpwm_pkg::*;
;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic timer_tick = 1'b0;
   tpwm_bus_req_t req = '0;
   logic [7:0] bus_rdata, d, m_cnt, m_cmp, m_buf, m_ca;
   logic wave_out_a, wave_out_b, m_up, m_seen, m_wa, m_blk, m_hi;
   logic [1:0] pin_out, pin_oe, m_flg, m_dir;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [16:0] tab [13] = '{17'h09300, 17'h093ff, 17'h09380, 17'h0d380,
      17'h05380, 17'h15305, 17'h19340, 17'h09140, 17'h09100, 17'h091ff,
      17'h15130, 17'h1d180, 17'h0c205};
   always #5 clk_sys = ~clk_sys;
   tpwm_timer DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .timer_tick(timer_tick), .bus_req(req), .bus_rdata(bus_rdata),
      .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .pin_out(pin_out),
      .pin_oe(pin_oe));
   task chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task chk_wave(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t wave=%h exp=%h", $time, got, exp);
      end
   endtask : chk_wave
   task finish_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // Reference timer, stepped on every tick the design sees
   task automatic mstep();
      logic [2:0] md;
      logic [7:0] top;
      logic [1:0] act;
      logic hit, lvl;
      md = {m_hi, m_ca[1:0]};
      act = m_ca[7:6];
      top = (md == MODE_CLEAR_ON_MATCH || md[2]) ? m_cmp : CNT_MAX;
      hit = m_cnt == m_cmp && !m_blk;
      lvl = act == ACT_SET;
      m_blk = 1'b0;
      m_flg[1] = m_flg[1] | hit;
      if (hit && act == ACT_TOGGLE && (md == MODE_CLEAR_ON_MATCH || md[2]))
         m_wa = !m_wa;
      if (md == MODE_CLEAR_ON_MATCH)
      begin
         // Set or clear actions outside PWM act on the match itself
         if (hit && act[1])
            m_wa = act[0];
         m_flg[0] = m_flg[0] | (!hit && m_cnt == CNT_MAX);
         m_cnt = hit ? CNT_BOTTOM : m_cnt + 8'h01;
      end
      else if (md[1])
      begin
         if (hit && m_cmp != top && act[1])
            m_wa = lvl;
         if (m_cnt == top)
         begin
            m_flg[0] = 1'b1;
            m_cmp = m_buf;
            m_wa = act[1] ? !lvl : m_wa;
         end
         m_cnt = (m_cnt == top) ? CNT_BOTTOM : m_cnt + 8'h01;
      end
      else
      begin
         if (m_cnt == CNT_BOTTOM && !m_up)
         begin
            m_flg[0] = 1'b1;
            m_up = 1'b1;
            if (!m_seen && m_cmp != top && act[1])
               m_wa = lvl;
            m_seen = 1'b0;
         end
         if (hit && m_cmp != top && act[1])
         begin
            m_wa = m_up ? lvl : !lvl;
            m_seen = m_seen | m_up;
         end
         if (m_up && m_cnt == top)
         begin
            m_wa = (m_cmp == top && act[1]) ? !lvl : m_wa;
            m_cmp = m_buf;
            m_up = 1'b0;
         end
         m_cnt = m_up ? m_cnt + 8'h01 : m_cnt - 8'h01;
      end
   endtask : mstep
   // Cycle ceiling and model stepping
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles > 100000)
      begin
         miscompares++;
         finish_test();
      end
      if (!sys_rst && timer_tick)
         mstep();
   end
   // Waves compared every cycle; channel B is never given a live action
   always @(negedge clk_sys)
      if (!sys_rst)
         chk_wave({wave_out_b, wave_out_a}, {1'b0, m_wa});
   task rst();
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      {m_cnt, m_cmp, m_buf, m_ca, m_seen, m_wa, m_blk, m_hi, m_flg} = '0;
      m_dir = 2'h0;
      m_up = 1'b1;
   endtask : rst
   // Bus write, mirrored into the model
   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, a, v};
      @(posedge clk_sys);
      req <= '0;
      case (a)
         REG_CTRL_A: m_ca = v;
         REG_CTRL_B: m_hi = v[MODE_HIGH_BIT];
         REG_COUNT: {m_cnt, m_blk} = {v, 1'b1};
         REG_CMP_A: {m_buf, m_cmp} = {v, m_ca[0] ? m_cmp : v};
         REG_FLAGS: m_flg = m_flg & ~v[1:0];
         REG_PIN_DIR: m_dir = v[1:0];
         default: ;
      endcase
   endtask : wr
   task rd(input logic [2:0] a);
      @(posedge clk_sys);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      req <= '0;
      @(negedge clk_sys);
      d = bus_rdata;
      // End on a rising edge so the next drive lands on one
      @(posedge clk_sys);
   endtask : rd
   // Exactly n ticks at random spacing, tick low afterwards
   task ticks(input int n);
      int k;
      k = 0;
      while (k < n)
      begin
         @(posedge clk_sys);
         k += int'(timer_tick);
         timer_tick <= (k < n) ? 1'($urandom) : 1'b0;
      end
   endtask : ticks
   task cfg(input logic hi, input logic [7:0] ca, input logic [7:0] c);
      wr(REG_CMP_A, c);
      wr(REG_CTRL_B, {4'h0, hi, 3'h0});
      wr(REG_CTRL_A, ca);
      wr(REG_PIN_DIR, 8'h03);
   endtask : cfg
   task chk_state();
      rd(REG_COUNT);
      chk8(d, m_cnt);
      rd(REG_FLAGS);
      chk8(d & 8'h03, {6'h00, m_flg});
      chk_wave(pin_oe, m_dir);
      chk_wave(pin_out, {1'b0, m_ca[7:6] != ACT_OFF && m_wa});
      $display("test step done t=%0t", $time);
   endtask : chk_state
   initial
   begin
      void'($urandom(71787));
      rst();
      wr(3'h7, 8'h5a);
      for (int a = 0; a < 8; a++)
      begin
         rd(3'(a));
         chk8(d, 8'h00);
      end
      rst();
      cfg(1'b0, 8'h42, 8'h03);
      ticks(22);
      chk_state();
      wr(REG_CMP_A, 8'h01);
      ticks(300);
      chk_state();
      wr(REG_FLAGS, 8'h07);
      chk_state();
      foreach (tab[i])
      begin
         rst();
         cfg(tab[i][16], tab[i][15:8], tab[i][7:0]);
         ticks(1100);
         chk_state();
      end
      rst();
      cfg(1'b0, 8'h91, 8'hff);
      ticks(600);
      wr(REG_CMP_A, 8'h40);
      rd(REG_CMP_A);
      chk8(d, 8'h40);
      ticks(1100);
      chk_state();
      rst();
      cfg(1'b0, 8'hd1, 8'h10);
      wr(REG_COUNT, 8'h80);
      ticks(600);
      chk_state();
      finish_test();
   end
endmodule : testbench
`default_nettype wire

// ==== verification/tpwm_monitor.sv ====
// Port assertions of the waveform timer, bound to its top
`timescale 1ns/1ns
`default_nettype none
module tpwm_monitor
   import tpwm_pkg::*;
(
   // Clock, reset and tick
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic timer_tick,
   // Register port
   input wire tpwm_bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   // Waves and pins
   input wire logic wave_out_a,
   input wire logic wave_out_b,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe
);
   logic [7:0] ca_q;
   logic hi_q;
   logic dw;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // Shadow control A so the checks know mode and actions
   always_ff @(posedge clk_sys)
      if (sys_rst)
         ca_q <= CTRL_RESET;
      else if (bus_req.wr && bus_req.addr == REG_CTRL_A)
         ca_q <= bus_req.wdata;
   // Shadow of the mode high bit
   always_ff @(posedge clk_sys)
      if (sys_rst)
         hi_q <= 1'b0;
      else if (bus_req.wr && bus_req.addr == REG_CTRL_B)
         hi_q <= bus_req.wdata[MODE_HIGH_BIT];
   assign dw = bus_req.wr && bus_req.addr == REG_PIN_DIR;
   // Read data shows only after a read strobe
   a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == RD_IDLE)
      else $error("read data not idle");
   a_oe_load: assert property (dw |=> ##1 pin_oe == $past(bus_req.wdata[1:0], 2))
      else $error("pin enable not loaded");
   a_oe_hold: assert property (!dw |=> ##1 $stable(pin_oe))
      else $error("pin enable moved");
   a_pin_wave: assert property ((pin_out & ~{$past(wave_out_b), $past(wave_out_a)}) == 2'b00)
      else $error("pin shows no wave");
   a_pin_quiet: assert property (ca_q[7:6] == ACT_OFF |=> !pin_out[0])
      else $error("pin driven with action off");
   a_tick_gate: assert property (!timer_tick |=> $stable({wave_out_a, wave_out_b}))
      else $error("wave moved without tick");
   a_b_no_toggle: assert property (ca_q[0] && ca_q[5:4] == ACT_TOGGLE |=> $stable(wave_out_b))
      else $error("channel B toggled in PWM");
   a_a_gated: assert property (ca_q[0] && !hi_q && ca_q[7:6] == ACT_TOGGLE |=> $stable(wave_out_a))
      else $error("channel A toggled without high bit");
endmodule : tpwm_monitor
bind tpwm_timer tpwm_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .timer_tick(timer_tick), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .pin_out(pin_out),
   .pin_oe(pin_oe));
`default_nettype wire
